// ### design/wcoc_ctrl.sv
/*
 wcoc_ctrl: wake-up and checksum offload control registers, wake filter
 load port, indexed phy register access and the wake interrupt.
 assumes a single-cycle register master and a receive path that marks
 frames with sof/eof and reports filter hits as one-cycle pulses.
*/
// Added by the designer: strobed register access.
`default_nettype none
module wcoc_ctrl
    import wcoc_pkg::*;
#(
    parameter logic [15:0] PHY_ID1_VAL = 16'h1234, // arbitrary value
    parameter logic [15:0] PHY_ID2_VAL = 16'h5678 // arbitrary value
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // receive path
    input wire logic rx_byte_valid,
    input wire logic rx_sof,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eof,
    input wire logic rx_good,
    input wire logic wake_frame_hit,
    input wire logic [47:0] mac_addr,
    input wire logic [1:0] rx_vlan_tags,
    input wire logic rx_snap,
    input wire logic power_save,
    // controls and events
    output logic wake_request,
    output logic tx_csum_engine_en,
    output logic rx_csum_engine_en,
    output logic rx_csum_start_mode,
    output logic [5:0] rx_csum_start_offset,
    output logic [32*FILTER_WORDS-1:0] wake_filter_words,
    output logic phy_soft_reset,
    output logic irq
);
    logic global_unicast_wake_en, wake_frame_detect_en, magic_packet_wake_en;
    logic wake_frame_received, magic_packet_received;
    logic [IRQ_W-1:0] irq_status, irq_enable, irq_events;
    logic [2:0] filt_ptr;
    logic [15:0] phy_mem [32];
    logic [15:0] phy_data;
    logic [4:0] phy_idx;
    logic unicast_dest, mp_found;
    logic wf_evt, mp_evt, gu_evt, wsel_ok;
    logic w_filt, w_wake, w_csum, w_acc, w_data, w_iclr, w_ien, phy_rst_go;
    logic [5:0] next_offset;
    logic [31:0] next_rdata;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    function automatic logic phy_valid(input logic [4:0] i);
        return i <= PHY_ANEXP || i == PHY_MODE || i == PHY_SMODES ||
            i == PHY_SIND || i >= PHY_ISRC;
    endfunction : phy_valid

    function automatic logic phy_writable(input logic [4:0] i);
        return i == PHY_BCR || i == PHY_ANAR || i == PHY_MODE ||
            i == PHY_SMODES || i == PHY_SIND || i == PHY_IMASK || i == PHY_SCSR;
    endfunction : phy_writable

    function automatic logic [15:0] phy_default(input logic [4:0] i);
        case (i)
            PHY_BCR: return PHY_BCR_DEF;
            PHY_BSR: return PHY_BSR_DEF;
            PHY_ID1: return PHY_ID1_VAL;
            PHY_ID2: return PHY_ID2_VAL;
            default: return 16'h0000;
        endcase
    endfunction : phy_default

    // word-aligned decode; misaligned or unmapped writes are dropped
    assign wsel_ok = wr && addr[1:0] == 2'h0;
    assign w_filt = wsel_ok && addr[7:2] == IDX_WAKE_FILTER;
    assign w_wake = wsel_ok && addr[7:2] == IDX_WAKE_CTRL;
    assign w_csum = wsel_ok && addr[7:2] == IDX_CSUM_CTRL;
    assign w_acc = wsel_ok && addr[7:2] == IDX_PHY_ACC;
    assign w_data = wsel_ok && addr[7:2] == IDX_PHY_DATA;
    assign w_iclr = wsel_ok && addr[7:2] == IDX_IRQ_CLEAR;
    assign w_ien = wsel_ok && addr[7:2] == IDX_IRQ_ENABLE;
    assign phy_idx = wdata[PACC_IDX_LSB +: 5];
    assign phy_rst_go = w_acc && wdata[PACC_WRITE] && phy_idx == PHY_BCR &&
        phy_data[PHY_BCR_RST];

    wcoc_magic_detect u_magic (
        .clock(clock),
        .rst_b(rst_b),
        .rx_byte_valid(rx_byte_valid),
        .rx_sof(rx_sof),
        .rx_byte(rx_byte),
        .rx_eof(rx_eof),
        .rx_good(rx_good),
        .mac_addr(mac_addr),
        .found(mp_found)
    );

    // destination bit 0 is the first bit of the first byte on the wire
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            unicast_dest <= 1'b0;
        end else if (rx_byte_valid && rx_sof) begin
            unicast_dest <= !rx_byte[0];
        end
    end

    assign wf_evt = wake_frame_hit && wake_frame_detect_en;
    assign mp_evt = mp_found && magic_packet_wake_en;
    assign gu_evt = rx_byte_valid && rx_eof && rx_good && !rx_sof &&
        unicast_dest && global_unicast_wake_en;
    assign irq_events = {gu_evt, mp_evt, wf_evt};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            global_unicast_wake_en <= WCS_RESET[WCS_GUE];
            wake_frame_detect_en <= WCS_RESET[WCS_WAKE_FRAME_DETECT_EN];
            magic_packet_wake_en <= WCS_RESET[WCS_MAGIC_PACKET_WAKE_EN];
        end else if (w_wake) begin
            global_unicast_wake_en <= wdata[WCS_GUE];
            wake_frame_detect_en <= wdata[WCS_WAKE_FRAME_DETECT_EN];
            magic_packet_wake_en <= wdata[WCS_MAGIC_PACKET_WAKE_EN];
        end
    end

    // writing one to a flag clears it; a same-cycle event wins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake_frame_received <= WCS_RESET[WCS_WAKE_FRAME_RECEIVED];
            magic_packet_received <= WCS_RESET[WCS_MPR];
        end else begin
            if (wf_evt) begin
                wake_frame_received <= 1'b1;
            end else if (w_wake && wdata[WCS_WAKE_FRAME_RECEIVED]) begin
                wake_frame_received <= 1'b0;
            end
            if (mp_evt) begin
                magic_packet_received <= 1'b1;
            end else if (w_wake && wdata[WCS_MPR]) begin
                magic_packet_received <= 1'b0;
            end
        end
    end

    // only meaningful while the system sleeps
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= power_save && (gu_evt || wf_evt || mp_evt);
        end
    end

    // no interlock against live traffic: software must idle the paths first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tx_csum_engine_en <= CSC_RESET[CSC_TX_EN];
            rx_csum_start_mode <= CSC_RESET[CSC_RX_MODE];
            rx_csum_engine_en <= CSC_RESET[CSC_RX_EN];
        end else if (w_csum) begin
            tx_csum_engine_en <= wdata[CSC_TX_EN];
            rx_csum_start_mode <= wdata[CSC_RX_MODE];
            rx_csum_engine_en <= wdata[CSC_RX_EN];
        end
    end

    always_comb begin
        next_offset = ETH_HDR_LEN;
        if (rx_csum_start_mode) begin
            next_offset = ETH_HDR_LEN + VLAN_TAG_LEN * {4'h0, rx_vlan_tags} +
                (rx_snap ? SNAP_LEN : 6'h00);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_csum_start_offset <= ETH_HDR_LEN;
        end else begin
            rx_csum_start_offset <= next_offset;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            filt_ptr <= 3'h0;
            wake_filter_words <= '0;
        end else if (w_filt) begin
            wake_filter_words[32 * filt_ptr +: 32] <= wdata;
            filt_ptr <= filt_ptr + 3'h1;
        end
    end

    // access completes in one cycle, so the busy bit always reads zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 32; i++) begin
                phy_mem[i] <= phy_default(5'(i));
            end
            phy_data <= 16'h0000;
        end else if (phy_rst_go) begin
            for (int i = 0; i < 32; i++) begin
                if (5'(i) != PHY_MODE && 5'(i) != PHY_SMODES) begin
                    phy_mem[i] <= phy_default(5'(i));
                end
            end
        end else if (w_acc) begin
            if (wdata[PACC_WRITE]) begin
                if (phy_writable(phy_idx)) begin
                    phy_mem[phy_idx] <= phy_data;
                end
            end else begin
                phy_data <= phy_valid(phy_idx) ? phy_mem[phy_idx] : 16'h0000;
            end
        end else if (w_data) begin
            phy_data <= wdata[15:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phy_soft_reset <= 1'b0;
        end else begin
            phy_soft_reset <= phy_rst_go;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            irq_status <= irq_events | (irq_status & ~(w_iclr ? wdata[IRQ_W-1:0] : '0));
            if (w_ien) begin
                irq_enable <= wdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd && addr[1:0] == 2'h0) begin
            case (addr[7:2])
                IDX_WAKE_CTRL: begin
                    next_rdata[WCS_GUE] = global_unicast_wake_en;
                    next_rdata[WCS_WAKE_FRAME_RECEIVED] = wake_frame_received;
                    next_rdata[WCS_MPR] = magic_packet_received;
                    next_rdata[WCS_WAKE_FRAME_DETECT_EN] = wake_frame_detect_en;
                    next_rdata[WCS_MAGIC_PACKET_WAKE_EN] = magic_packet_wake_en;
                end
                IDX_CSUM_CTRL: begin
                    next_rdata[CSC_TX_EN] = tx_csum_engine_en;
                    next_rdata[CSC_RX_MODE] = rx_csum_start_mode;
                    next_rdata[CSC_RX_EN] = rx_csum_engine_en;
                end
                IDX_PHY_DATA: next_rdata[15:0] = phy_data;
                IDX_IRQ_STATUS: next_rdata[IRQ_W-1:0] = irq_status;
                IDX_IRQ_ENABLE: next_rdata[IRQ_W-1:0] = irq_enable;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    uni_wake_a: assert property (gu_evt && power_save |=> wake_request)
        else $error("unicast frame did not wake");
    wfr_set_a: assert property (wake_frame_hit && wake_frame_detect_en
        |=> wake_frame_received && irq_status[IRQ_WAKE_FRAME])
        else $error("wake frame flag not set");
    mpr_set_a: assert property (mp_found && magic_packet_wake_en
        |=> magic_packet_received)
        else $error("magic flag not set");
    wf_gate_a: assert property ($rose(wake_frame_received)
        |-> $past(wake_frame_hit && wake_frame_detect_en))
        else $error("wake flag rose without enabled hit");
    mp_gate_a: assert property ($rose(magic_packet_received)
        |-> $past(mp_found && magic_packet_wake_en))
        else $error("magic flag rose without enable");
    tx_csum_a: assert property (w_csum
        |=> tx_csum_engine_en == $past(wdata[CSC_TX_EN]))
        else $error("tx engine enable wrong");
    rx_off_a: assert property (!rx_csum_start_mode
        |=> rx_csum_start_offset == ETH_HDR_LEN)
        else $error("rx start offset not 14");
    rx_csum_a: assert property (w_csum
        |=> rx_csum_engine_en == $past(wdata[CSC_RX_EN]))
        else $error("rx engine enable wrong");
    ptr_wrap_a: assert property (w_filt && filt_ptr == 3'h7 |=> filt_ptr == 3'h0)
        else $error("filter pointer failed to wrap");
    phy_rst_a: assert property (phy_rst_go |=> phy_mem[PHY_BCR] == PHY_BCR_DEF &&
        phy_mem[PHY_MODE] == $past(phy_mem[PHY_MODE]) && phy_soft_reset)
        else $error("phy soft reset wrong");
    phy_idx_a: assert property (w_acc && !wdata[PACC_WRITE] && !phy_valid(phy_idx)
        |=> phy_data == 16'h0000)
        else $error("unmapped phy index read nonzero");
    flag_hold_a: assert property (wake_frame_received && !(w_wake && wdata[WCS_WAKE_FRAME_RECEIVED])
        |=> wake_frame_received)
        else $error("wake flag dropped");
    magic_wake_c: cover property (mp_evt && power_save ##1 wake_request);
    filt_wrap_c: cover property (w_filt && filt_ptr == 3'h7);
    irq_c: cover property ($rose(irq));
    phy_rst_c: cover property (phy_rst_go);
endmodule : wcoc_ctrl
`default_nettype wire

// ### design/wcoc_magic_detect.sv
/*
 wcoc_magic_detect: magic packet recogniser on the receive byte stream.
 assumes the first byte of a frame comes with rx_sof and the last with
 rx_eof, rx_good qualifying the frame at rx_eof.
*/
`default_nettype none
module wcoc_magic_detect
    import wcoc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // receive stream
    input wire logic rx_byte_valid,
    input wire logic rx_sof,
    input wire logic [7:0] rx_byte,
    input wire logic rx_eof,
    input wire logic rx_good,
    input wire logic [47:0] mac_addr,
    // one-cycle pulse after a good frame holding a magic pattern
    output logic found
);
    logic [2:0] sync_cnt;
    logic [2:0] pos;
    logic [4:0] reps;
    logic hunting;
    logic seen;
    logic [7:0] want;
    logic is_ff;
    logic done_now;

    assign want = mac_addr[8 * pos +: 8];
    assign is_ff = (rx_byte == 8'hff);
    // the last address copy may sit on the eof byte itself, before seen can rise
    assign done_now = hunting && !rx_sof && rx_byte == want &&
        pos == 3'(MAC_BYTES - 1) && reps == 5'(MAGIC_REPS - 1);

    // a mismatch inside the address run falls back to sync hunting
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync_cnt <= 3'h0;
            pos <= 3'h0;
            reps <= 5'h00;
            hunting <= 1'b0;
            seen <= 1'b0;
        end else if (rx_byte_valid) begin
            if (rx_sof) begin
                seen <= 1'b0;
            end
            if (hunting && rx_byte == want && !(rx_sof)) begin
                if (pos == 3'(MAC_BYTES - 1)) begin
                    pos <= 3'h0;
                    reps <= reps + 5'h01;
                    if (reps == 5'(MAGIC_REPS - 1)) begin
                        seen <= 1'b1;
                        hunting <= 1'b0;
                        sync_cnt <= 3'h0;
                    end
                end else begin
                    pos <= pos + 3'h1;
                end
            end else if (!rx_sof && sync_cnt == 3'(MAGIC_SYNC) &&
                         rx_byte == mac_addr[7:0] && !is_ff) begin
                hunting <= 1'b1;
                pos <= 3'h1;
                reps <= 5'h00;
            end else begin
                hunting <= 1'b0;
                if (is_ff) begin
                    sync_cnt <= (sync_cnt == 3'(MAGIC_SYNC) || rx_sof) ?
                        (rx_sof ? 3'h1 : sync_cnt) : sync_cnt + 3'h1;
                end else begin
                    sync_cnt <= 3'h0;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            found <= 1'b0;
        end else begin
            found <= rx_byte_valid && rx_eof && rx_good && (seen || done_now);
        end
    end
endmodule : wcoc_magic_detect
`default_nettype wire

// ### shared/wcoc_pkg.sv
/*
 wcoc_pkg: register indices, field positions, reset values and frame
 constants for the wake and checksum offload control block.
 assumes byte addressing on the register port, one 32-bit word per index.
*/
`default_nettype none
package wcoc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_PHY_ACC = 6'h06;
    localparam logic [5:0] IDX_PHY_DATA = 6'h07;
    localparam logic [5:0] IDX_WAKE_FILTER = 6'h0b;
    localparam logic [5:0] IDX_WAKE_CTRL = 6'h0c;
    localparam logic [5:0] IDX_CSUM_CTRL = 6'h0d;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
    // wake_control_status fields
    localparam int WCS_GUE = 9;
    localparam int WCS_WAKE_FRAME_RECEIVED = 6;
    localparam int WCS_MPR = 5;
    localparam int WCS_WAKE_FRAME_DETECT_EN = 2;
    localparam int WCS_MAGIC_PACKET_WAKE_EN = 1;
    localparam logic [31:0] WCS_RESET = 32'h0000_0000;
    // checksum_offload_control fields
    localparam int CSC_TX_EN = 16;
    localparam int CSC_RX_MODE = 1;
    localparam int CSC_RX_EN = 0;
    localparam logic [31:0] CSC_RESET = 32'h0000_0000;
    // interrupt status, clear and enable layout
    localparam int IRQ_WAKE_FRAME = 0;
    localparam int IRQ_MAGIC = 1;
    localparam int IRQ_UNICAST = 2;
    localparam int IRQ_W = 3;
    // phy_mgmt_access_reg fields
    localparam int PACC_IDX_LSB = 6;
    localparam int PACC_WRITE = 1;
    // phy register indices and defaults
    localparam logic [4:0] PHY_BCR = 5'd0;
    localparam logic [4:0] PHY_BSR = 5'd1;
    localparam logic [4:0] PHY_ID1 = 5'd2;
    localparam logic [4:0] PHY_ID2 = 5'd3;
    localparam logic [4:0] PHY_ANAR = 5'd4;
    localparam logic [4:0] PHY_ANEXP = 5'd6;
    localparam logic [4:0] PHY_MODE = 5'd17;
    localparam logic [4:0] PHY_SMODES = 5'd18;
    localparam logic [4:0] PHY_SIND = 5'd27;
    localparam logic [4:0] PHY_ISRC = 5'd29;
    localparam logic [4:0] PHY_IMASK = 5'd30;
    localparam logic [4:0] PHY_SCSR = 5'd31;
    localparam int PHY_BCR_RST = 15;
    localparam logic [15:0] PHY_BCR_DEF = 16'h1000;
    localparam logic [15:0] PHY_BSR_DEF = 16'h7809;
    // frame layout
    localparam logic [5:0] ETH_HDR_LEN = 6'h0e;
    localparam logic [5:0] VLAN_TAG_LEN = 6'h04;
    localparam logic [5:0] SNAP_LEN = 6'h08;
    localparam int FILTER_WORDS = 8;
    localparam int MAGIC_SYNC = 6;
    localparam int MAGIC_REPS = 16;
    localparam int MAC_BYTES = 6;
endpackage : wcoc_pkg
`default_nettype wire

// ### tb/wcoc_ctrl_test.sv
/*
 wcoc_ctrl_test: self-checking bench for the wake and checksum offload control block.
 assumes the single-cycle register port, read data in the cycle after the
 read strobe, and wake events reported by sticky status bits.
*/
`default_nettype none
module wcoc_ctrl_test;
    import wcoc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID1 = 16'h2a5c; // arbitrary value
    localparam logic [15:0] ID2 = 16'h3b6d; // arbitrary value
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic rx_byte_valid = 1'b0;
    logic rx_sof = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic rx_eof = 1'b0;
    logic rx_good = 1'b0;
    logic wake_frame_hit = 1'b0;
    logic [47:0] mac_addr = 48'h665544332211;
    logic [1:0] rx_vlan_tags = 2'h2;
    logic rx_snap = 1'b1;
    logic power_save = 1'b1;
    logic wake_request, tx_csum_engine_en, rx_csum_engine_en, rx_csum_start_mode;
    logic [5:0] rx_csum_start_offset;
    logic [32*FILTER_WORDS-1:0] wake_filter_words;
    logic phy_soft_reset, irq;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int wake_cnt = 0;
    int prst_cnt = 0;
    logic [7:0] fbytes[$];
    wcoc_ctrl #(.PHY_ID1_VAL(ID1), .PHY_ID2_VAL(ID2)) dut (
        .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rx_byte_valid(rx_byte_valid), .rx_sof(rx_sof), .rx_byte(rx_byte),
        .rx_eof(rx_eof), .rx_good(rx_good), .wake_frame_hit(wake_frame_hit),
        .mac_addr(mac_addr), .rx_vlan_tags(rx_vlan_tags), .rx_snap(rx_snap),
        .power_save(power_save), .wake_request(wake_request),
        .tx_csum_engine_en(tx_csum_engine_en), .rx_csum_engine_en(rx_csum_engine_en),
        .rx_csum_start_mode(rx_csum_start_mode), .rx_csum_start_offset(rx_csum_start_offset),
        .wake_filter_words(wake_filter_words), .phy_soft_reset(phy_soft_reset), .irq(irq)
    );
    always #50 clock = ~clock;
    // the ceiling stays far above the few hundred cycles the sequence needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (wake_request === 1'b1) wake_cnt <= wake_cnt + 1;
        if (phy_soft_reset === 1'b1) prst_cnt <= prst_cnt + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_clk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg
    // data only stand in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(rdata, exp, msg);
    endtask : rd_chk
    task automatic send_frame();
        foreach (fbytes[i]) begin
            @(posedge clock);
            rx_byte_valid <= 1'b1;
            rx_byte <= fbytes[i];
            rx_sof <= (i == 0);
            rx_eof <= (i == fbytes.size() - 1);
            rx_good <= (i == fbytes.size() - 1);
        end
        @(posedge clock);
        rx_byte_valid <= 1'b0;
        rx_eof <= 1'b0;
        rx_good <= 1'b0;
        wait_clk(4);
    endtask : send_frame
    task automatic hit_pulse();
        @(posedge clock);
        wake_frame_hit <= 1'b1;
        @(posedge clock);
        wake_frame_hit <= 1'b0;
        wait_clk(3);
    endtask : hit_pulse
    task automatic phy_rd(input logic [4:0] idx, input logic [31:0] exp, input string msg);
        wr_reg(8'h18, {21'h0, idx, 6'h00});
        rd_chk(8'h1c, exp, msg);
    endtask : phy_rd
    task automatic phy_wr(input logic [4:0] idx, input logic [15:0] d);
        wr_reg(8'h1c, {16'h0, d});
        wr_reg(8'h18, {21'h0, idx, 6'h02});
    endtask : phy_wr
    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        rd_chk(8'h30, WCS_RESET, "wake reg reset");
        rd_chk(8'h34, CSC_RESET, "csum reg reset");
        check({26'h0, rx_csum_start_offset}, 32'he, "reset offset");
        wr_reg(8'h34, 32'h0001_0003);
        wait_clk(3);
        check({tx_csum_engine_en, rx_csum_engine_en, rx_csum_start_mode}, 3'h7, "csum on");
        check({26'h0, rx_csum_start_offset}, 32'h1e, "l3 offset");
        rd_chk(8'h34, 32'h0001_0003, "csum readback");
        wr_reg(8'h34, 32'h0000_0001);
        wait_clk(3);
        check({tx_csum_engine_en, rx_csum_engine_en, rx_csum_start_mode}, 3'h2, "tx off");
        check({26'h0, rx_csum_start_offset}, 32'he, "fixed offset");
        wr_reg(8'h34, 32'h0);
        wait_clk(2);
        check({31'h0, rx_csum_engine_en}, 32'h0, "rx off");
        wr_reg(8'h48, 32'h7);
        rd_chk(8'h48, 32'h7, "irq enable readback");
        wr_reg(8'h30, 32'h200);
        fbytes = '{8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h08, 8'h00};
        send_frame();
        fbytes[0] = 8'h03;
        send_frame();
        check(wake_cnt, 32'h1, "unicast wake count");
        check({31'h0, irq}, 32'h1, "irq on unicast");
        rd_chk(8'h40, 32'h4, "unicast status");
        power_save <= 1'b0;
        fbytes[0] = 8'h02;
        send_frame();
        check(wake_cnt, 32'h1, "awake no wake");
        power_save <= 1'b1;
        rd_chk(8'h30, 32'h200, "gue readback");
        wr_reg(8'h48, 32'h0);
        wait_clk(3);
        check({31'h0, irq}, 32'h0, "irq masked");
        wr_reg(8'h48, 32'h7);
        wr_reg(8'h44, 32'h4);
        wait_clk(3);
        rd_chk(8'h40, 32'h0, "status cleared");
        check({31'h0, irq}, 32'h0, "irq cleared");
        hit_pulse();
        rd_chk(8'h30, 32'h200, "hit ignored");
        wr_reg(8'h30, 32'h4);
        hit_pulse();
        rd_chk(8'h30, 32'h44, "wake frame flag");
        wait_clk(5);
        rd_chk(8'h30, 32'h44, "wake flag holds");
        fbytes.delete();
        repeat (MAGIC_SYNC) fbytes.push_back(8'hff);
        repeat (MAGIC_REPS) for (int k = 0; k < MAC_BYTES; k++) fbytes.push_back(mac_addr[8*k +: 8]);
        send_frame();
        rd_chk(8'h30, 32'h44, "magic ignored");
        wr_reg(8'h30, 32'h6);
        send_frame();
        rd_chk(8'h30, 32'h66, "magic flag");
        rd_chk(8'h40, 32'h3, "frame and magic status");
        wr_reg(8'h30, 32'h66);
        rd_chk(8'h30, 32'h6, "flags cleared");
        wr_reg(8'h44, 32'h3);
        rd_chk(8'h40, 32'h0, "status cleared again");
        for (int k = 0; k <= FILTER_WORDS; k++) wr_reg(8'h2c, 32'hc0de_0000 + k);
        wait_clk(1);
        for (int k = 0; k < FILTER_WORDS; k++) begin
            check(wake_filter_words[32*k +: 32], 32'hc0de_0000 + (k == 0 ? 8 : k), "filter");
        end
        rd_chk(8'h2c, 32'h0, "filter write only");
        rd_chk(8'h3c, 32'h0, "unmapped read");
        phy_rd(5'd1, 32'h7809, "phy status");
        phy_rd(5'd2, {16'h0, ID1}, "phy id one");
        phy_rd(5'd3, {16'h0, ID2}, "phy id two");
        phy_wr(5'd4, 16'h01e1);
        phy_wr(5'd17, 16'h0002);
        phy_rd(5'd4, 32'h01e1, "phy advert");
        phy_wr(5'd0, 16'h8000);
        wait_clk(3);
        check(prst_cnt, 32'h1, "phy reset pulse");
        phy_rd(5'd0, 32'h1000, "phy control default");
        phy_rd(5'd4, 32'h0, "advert reset");
        phy_rd(5'd17, 32'h0002, "immune kept");
        wrap_up();
    end
endmodule : wcoc_ctrl_test
`default_nettype wire
